// [include/light_pkg.sv]
// constants, field layouts and state codes for the light sensor readout
package light_pkg;

  // ----------------------------------------
  // integration timing
  // ----------------------------------------
  localparam int GROUP_LEN     = 918;
  localparam int GROUPS_SHORT  = 11;
  localparam int GROUPS_MID    = 81;
  localparam int GROUPS_LONG   = 322;
  localparam int OSC_KHZ       = 735;
  localparam int INTEG_W       = 19;
  localparam logic [1:0] INTEG_SHORT = 2'h0;
  localparam logic [1:0] INTEG_MID   = 2'h1;
  localparam logic [1:0] INTEG_LONG  = 2'h2;

  // ----------------------------------------
  // converter counting
  // ----------------------------------------
  localparam logic [15:0] COUNT_MAX       = 16'hffff;
  localparam logic [1:0]  COUNT_OFFSET    = 2'h2;
  localparam logic [3:0]  LOW_GAIN_DIV_M1 = 4'hf;

  // ----------------------------------------
  // slave address strap
  // ----------------------------------------
  localparam logic [1:0] STRAP_GND   = 2'h0;
  localparam logic [1:0] STRAP_FLOAT = 2'h1;
  localparam logic [1:0] STRAP_VDD   = 2'h2;
  localparam logic [6:0] ADDR_GND    = 7'h29;
  localparam logic [6:0] ADDR_FLOAT  = 7'h39;
  localparam logic [6:0] ADDR_VDD    = 7'h49;

  // ----------------------------------------
  // register map and fields
  // ----------------------------------------
  localparam logic [3:0] REG_TIMING   = 4'h1;
  localparam logic [3:0] REG_DATA0_LO = 4'hc;
  localparam logic [3:0] REG_DATA0_HI = 4'hd;
  localparam logic [3:0] REG_DATA1_LO = 4'he;
  localparam logic [3:0] REG_DATA1_HI = 4'hf;
  localparam int         CMD_BIT      = 7;
  localparam int         WORD_BIT     = 5;
  localparam int         LOW_GAIN_BIT = 4;
  localparam logic [7:0] TIMING_RESET = 8'h02;
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  // ----------------------------------------
  // serial slave states
  // ----------------------------------------
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_ADDR  = 7'h02,
    ST_ACKA  = 7'h04,
    ST_WRITE = 7'h08,
    ST_ACKW  = 7'h10,
    ST_READ  = 7'h20,
    ST_ACKR  = 7'h40
  } i2c_state_t;

endpackage

// [rtl/light_channel.sv]
// one integrating converter channel: paced, offset, gain scaled, saturating
`timescale 1ns/1ps
module light_channel
  import light_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        light,
  input  wire logic        low_gain,
  output logic [15:0]      count
);

  logic       took;
  logic [1:0] skip;
  logic [3:0] pre;
  logic       take;
  logic       bump;

  // ----------------------------------------
  // count acceptance
  // ----------------------------------------
  always_comb
  begin
    take = light & ~took;                                        // R03
    bump = take & (skip == 2'h0) & (~low_gain | (pre == LOW_GAIN_DIV_M1)); // R05
  end

  always_ff @(posedge clk)
  begin
    if (rst | start)
      took <= 1'b0;
    else
      took <= take;                                              // R03
  end

  always_ff @(posedge clk)
  begin
    if (rst | start)
      skip <= COUNT_OFFSET;
    else if (take && skip != 2'h0)
      skip <= skip - 2'h1;                                       // R03
  end

  always_ff @(posedge clk)
  begin
    if (rst | start)
      pre <= 4'h0;
    else if (take && skip == 2'h0)
      pre <= pre + 4'h1;                                         // R05
  end

  always_ff @(posedge clk)
  begin
    if (rst | start)
      count <= 16'h0000;
    else if (bump && count != COUNT_MAX)
      count <= count + 16'h0001;                                 // R04 R16
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PACE: assert property (@(posedge clk) disable iff (rst) // R03
    (take && !start) |=> !take)
    else $error("two counts accepted in adjacent periods");

  AST_OFFSET: assert property (@(posedge clk) disable iff (rst) // R03
    (skip != 2'h0 && !start) |=> count == 16'h0000)
    else $error("count rose before offset was spent");

  AST_SAT: assert property (@(posedge clk) disable iff (rst) // R04 R16
    (count == COUNT_MAX && !start) |=> count == COUNT_MAX)
    else $error("full-scale count did not hold");

  AST_GAIN: assert property (@(posedge clk) disable iff (rst) // R05
    (low_gain && take && pre != LOW_GAIN_DIV_M1 && !start) |=> $stable(count))
    else $error("low gain counted off the divide point");

endmodule // light_channel

// [rtl/light_sensor_core.sv]
// two-channel light converter readout with serial register slave
// Notes on behaviour
// R01 - timing code 00/01/10 selects 11/81/322 groups of 918 oscillator cycles
// R02 - integration time is cycle count divided by oscillator rate
// R03 - at most one count per two oscillator periods, two-count offset
// R04 - counts limited to 65535 by sixteen-bit result
// R05 - low gain gives sixteen times fewer counts than high gain
// R06 - both channels integrate over one simultaneous window
// R07 - at cycle end broadband goes to channel-zero data, infrared to one
// R08 - result update double buffered so reads never see partial values; high byte is held only once low byte is read
// R09 - next integration starts by itself right after the transfer
// R10 - serial two-wire fast-mode slave; master keeps clock at most 400 kHz
// R11 - slave address from strap: low 0101001, float 0111001, high 1001001
// R12 - master sends seven-bit address plus direction bit as first byte
// R13 - host derives lux from count ratio; zero at ratio 1.30 or above
// R14 - byte with top bit set is a command; low four bits pick register
// R15 - read returns contents of register at stored register address
// R16 - a saturated count holds at full scale until cycle end
`timescale 1ns/1ps
module light_sensor_core
  import light_pkg::*;
#(
  parameter int GROUP_LEN_CYC = GROUP_LEN
)
(
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        OSC_CLK,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N,
  input  wire logic [1:0]  ADDR_STRAP,
  input  wire logic        BROADBAND_LIGHT,
  input  wire logic        INFRARED_LIGHT,
  output logic [15:0]      BROADBAND_COUNT,
  output logic [15:0]      INFRARED_COUNT,
  output logic             DATA_UPDATE,
  output logic             LOW_GAIN,
  output logic [1:0]       INTEG_SEL
);

  // ----------------------------------------
  // integration length decode
  // ----------------------------------------
  function automatic logic [INTEG_W-1:0] integ_last(input logic [1:0] code);
    case (code)
      INTEG_SHORT: integ_last = INTEG_W'(GROUPS_SHORT * GROUP_LEN_CYC - 1);
      INTEG_MID:   integ_last = INTEG_W'(GROUPS_MID * GROUP_LEN_CYC - 1);
      default:     integ_last = INTEG_W'(GROUPS_LONG * GROUP_LEN_CYC - 1);
    endcase
  endfunction

  // ----------------------------------------
  // oscillator domain: reset, settings, inputs
  // ----------------------------------------
  logic               orst1;
  logic               orst;
  logic [2:0]         set1;
  logic [2:0]         set2;
  logic [2:0]         set3;
  logic [2:0]         set_ok;
  logic [1:0]         win_code;
  logic [1:0]         lt1;
  logic [1:0]         lt2;
  logic [INTEG_W-1:0] cyc;
  logic [INTEG_W-1:0] cur_last;
  logic [INTEG_W-1:0] since;
  logic               seen;
  logic               cur_gain;
  logic               integ_end;
  logic [15:0]        chan_count [2];
  logic [15:0]        res [2];
  logic               xfer_tog;
  logic [7:0]         timing;

  always_ff @(posedge OSC_CLK)
  begin
    orst1 <= SYS_RST;
    orst  <= orst1;
    set1  <= {timing[LOW_GAIN_BIT], timing[1:0]};
    set2  <= set1;
    set3  <= set2;
    lt1   <= {INFRARED_LIGHT, BROADBAND_LIGHT};
    lt2   <= lt1;
  end

  // settings taken only once steady for two cycles
  always_ff @(posedge OSC_CLK)
  begin
    if (orst)
      set_ok <= {TIMING_RESET[LOW_GAIN_BIT], TIMING_RESET[1:0]};
    else if (set2 == set3)
      set_ok <= set2;
  end

  assign integ_end = (cyc == cur_last);

  always_ff @(posedge OSC_CLK)
  begin
    if (orst)
      cyc <= '0;
    else if (integ_end)
      cyc <= '0;                                                 // R09
    else
      cyc <= cyc + INTEG_W'(1);                                  // R01 R02
  end

  always_ff @(posedge OSC_CLK)
  begin
    if (orst)
    begin
      cur_last <= integ_last(TIMING_RESET[1:0]);
      cur_gain <= TIMING_RESET[LOW_GAIN_BIT];
      win_code <= TIMING_RESET[1:0];
    end
    else if (integ_end)
    begin
      cur_last <= integ_last(set_ok[1:0]);                       // R01
      cur_gain <= set_ok[2];                                     // R05
      win_code <= set_ok[1:0];
    end
  end

  // both channels share one window
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_chan
      light_channel u_chan (
        .clk      (OSC_CLK),
        .rst      (orst),
        .start    (integ_end),
        .light    (lt2[gi]),
        .low_gain (cur_gain),
        .count    (chan_count[gi])
      );                                                         // R06
    end
  endgenerate

  always_ff @(posedge OSC_CLK)
  begin
    if (orst)
    begin
      res[0]   <= 16'h0000;
      res[1]   <= 16'h0000;
      xfer_tog <= 1'b0;
    end
    else if (integ_end)
    begin
      res[0]   <= chan_count[0];                                 // R07
      res[1]   <= chan_count[1];                                 // R07
      xfer_tog <= ~xfer_tog;                                     // R08
    end
  end

  // cycle length monitor for checks
  always_ff @(posedge OSC_CLK)
  begin
    if (orst)
    begin
      since <= '0;
      seen  <= 1'b0;
    end
    else if (integ_end)
    begin
      since <= '0;
      seen  <= 1'b1;
    end
    else
      since <= since + INTEG_W'(1);
  end

  // ----------------------------------------
  // reference domain: input synchronisers
  // ----------------------------------------
  logic       x1, x2, x3;
  logic       scl1, scl2, scl3;
  logic       sda1, sda2, sda3;
  logic [1:0] strap1, strap2;
  logic       strap_done;
  logic [6:0] slave_addr;
  logic       load;
  logic       scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge REF_CLK)
  begin
    x1     <= xfer_tog;
    x2     <= x1;
    x3     <= x2;
    scl1   <= SCL_IN;
    scl2   <= scl1;
    scl3   <= scl2;
    sda1   <= SDA_IN;
    sda2   <= sda1;
    sda3   <= sda2;
    strap1 <= ADDR_STRAP;
    strap2 <= strap1;
  end

  always_comb
  begin
    load      = x2 ^ x3;
    scl_rise  = scl2 & ~scl3;
    scl_fall  = ~scl2 & scl3;
    bus_start = scl2 & scl3 & sda3 & ~sda2;
    bus_stop  = scl2 & scl3 & ~sda3 & sda2;
  end

  // strap caught once after reset release
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      strap_done <= 1'b0;
      slave_addr <= ADDR_FLOAT;
    end
    else if (!strap_done)
    begin
      strap_done <= 1'b1;
      case (strap2)
        STRAP_GND: slave_addr <= ADDR_GND;                       // R11
        STRAP_VDD: slave_addr <= ADDR_VDD;                       // R11
        default:   slave_addr <= ADDR_FLOAT;                     // R11
      endcase
    end
  end

  // ----------------------------------------
  // data registers and high-byte shadow
  // ----------------------------------------
  logic [15:0] dat [2];
  logic [7:0]  hi_hold [2];
  logic [1:0]  held;
  logic        rd_load;
  logic [7:0]  rd_byte;
  logic [3:0]  reg_addr;
  i2c_state_t  st;
  logic [7:0]  sh;
  logic [7:0]  tx;
  logic [3:0]  bitcnt;
  logic        word;

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      dat[0]      <= 16'h0000;
      dat[1]      <= 16'h0000;
      DATA_UPDATE <= 1'b0;
    end
    else
    begin
      DATA_UPDATE <= load;
      if (load)
      begin
        dat[0] <= res[0];                                        // R07 R08
        dat[1] <= res[1];                                        // R07 R08
      end
    end
  end

  assign BROADBAND_COUNT = dat[0];
  assign INFRARED_COUNT  = dat[1];
  assign LOW_GAIN        = timing[LOW_GAIN_BIT];
  assign INTEG_SEL       = timing[1:0];

  always_comb
  begin
    rd_load = scl_fall & ((st == ST_ACKA & sh[0]) | st == ST_ACKR);
    case (reg_addr)
      REG_TIMING:   rd_byte = timing;                            // R15
      REG_DATA0_LO: rd_byte = dat[0][7:0];
      REG_DATA0_HI: rd_byte = held[0] ? hi_hold[0] : dat[0][15:8]; // R08
      REG_DATA1_LO: rd_byte = dat[1][7:0];
      REG_DATA1_HI: rd_byte = held[1] ? hi_hold[1] : dat[1][15:8]; // R08
      default:      rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      held       <= 2'h0;
      hi_hold[0] <= 8'h00;
      hi_hold[1] <= 8'h00;
    end
    else if (rd_load)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (reg_addr == REG_DATA0_LO + 4'(2 * i))
        begin
          hi_hold[i] <= dat[i][15:8];                            // R08
          held[i]    <= 1'b1;
        end
        else if (reg_addr == REG_DATA0_HI + 4'(2 * i))
          held[i] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // serial slave
  // ----------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    SDA_OUT <= 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      st       <= ST_IDLE;
      bitcnt   <= 4'h0;
      sh       <= 8'h00;
      tx       <= 8'h00;
      SDA_OE_N <= 1'b1;
      reg_addr <= 4'h0;
      word     <= 1'b0;
      timing   <= TIMING_RESET;
    end
    else if (bus_stop)
    begin
      st       <= ST_IDLE;
      SDA_OE_N <= 1'b1;
    end
    else if (bus_start)
    begin
      st       <= ST_ADDR;                                       // R10 R12
      bitcnt   <= 4'h0;
      SDA_OE_N <= 1'b1;
    end
    else
    begin
      case (st)
        ST_ADDR, ST_WRITE:
        begin
          if (scl_rise)
          begin
            sh     <= {sh[6:0], sda2};
            bitcnt <= bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == BYTE_BITS)
          begin
            if (st == ST_ADDR)
            begin
              if (sh[7:1] == slave_addr)
              begin
                st       <= ST_ACKA;                             // R11 R12
                SDA_OE_N <= 1'b0;
              end
              else
                st <= ST_IDLE;
            end
            else
            begin
              st       <= ST_ACKW;
              SDA_OE_N <= 1'b0;
              if (sh[CMD_BIT])
              begin
                reg_addr <= sh[3:0];                             // R14
                word     <= sh[WORD_BIT];
              end
              else
              begin
                if (reg_addr == REG_TIMING)
                  timing <= sh;
                if (word)
                  reg_addr <= reg_addr + 4'h1;
              end
            end
          end
        end
        ST_ACKA, ST_ACKR:
        begin
          if (scl_rise && st == ST_ACKR && sda2)
            st <= ST_IDLE;
          else if (scl_fall)
          begin
            bitcnt <= 4'h0;
            if (rd_load)
            begin
              st       <= ST_READ;
              tx       <= rd_byte;                               // R15
              SDA_OE_N <= rd_byte[7];
              if (word)
                reg_addr <= reg_addr + 4'h1;
            end
            else
            begin
              st       <= ST_WRITE;
              SDA_OE_N <= 1'b1;
            end
          end
        end
        ST_ACKW:
        begin
          if (scl_fall)
          begin
            st       <= ST_WRITE;
            bitcnt   <= 4'h0;
            SDA_OE_N <= 1'b1;
          end
        end
        ST_READ:
        begin
          if (scl_rise)
            bitcnt <= bitcnt + 4'h1;
          else if (scl_fall)
          begin
            if (bitcnt == BYTE_BITS)
            begin
              st       <= ST_ACKR;
              SDA_OE_N <= 1'b1;
            end
            else
            begin
              SDA_OE_N <= tx[6];
              tx       <= {tx[6:0], 1'b0};
            end
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_addr_match;
    st == ST_ADDR && scl_fall && bitcnt == BYTE_BITS && sh[7:1] == slave_addr
      && !bus_start && !bus_stop;
  endsequence

  sequence s_cmd_byte;
    st == ST_WRITE && scl_fall && bitcnt == BYTE_BITS && sh[CMD_BIT]
      && !bus_start && !bus_stop;
  endsequence

  AST_INTEG_LEN: assert property (@(posedge OSC_CLK) disable iff (orst) // R01 R02
    (integ_end && seen) |-> since == ((win_code == INTEG_SHORT)
      ? INTEG_W'(GROUPS_SHORT * GROUP_LEN_CYC - 1)
      : (win_code == INTEG_MID) ? INTEG_W'(GROUPS_MID * GROUP_LEN_CYC - 1)
      : INTEG_W'(GROUPS_LONG * GROUP_LEN_CYC - 1)))
    else $error("integration window length wrong");

  AST_RESTART: assert property (@(posedge OSC_CLK) disable iff (orst) // R06 R09
    integ_end |=> cyc == '0 && chan_count[0] == 16'h0000 && chan_count[1] == 16'h0000)
    else $error("next integration did not start together");

  AST_RESULT: assert property (@(posedge OSC_CLK) disable iff (orst) // R07
    integ_end |=> res[0] == $past(chan_count[0]) && res[1] == $past(chan_count[1]))
    else $error("results not captured at cycle end");

  AST_XFER: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // R07 R08
    load |=> DATA_UPDATE && BROADBAND_COUNT == res[0] && INFRARED_COUNT == res[1])
    else $error("data registers not updated from results");

  AST_HI_COHERENT: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // R08
    (rd_load && reg_addr == REG_DATA0_HI && held[0] && !bus_stop && !bus_start)
      |=> tx == $past(hi_hold[0]))
    else $error("high byte not taken from held copy");

  AST_ADDR_ACK: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // R11
    s_addr_match |=> st == ST_ACKA && !SDA_OE_N)
    else $error("own address not acknowledged");

  AST_CMD: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // R14
    s_cmd_byte |=> reg_addr == $past(sh[3:0]) && st == ST_ACKW && !SDA_OE_N)
    else $error("command byte did not set register address");

  AST_READ: assert property (@(posedge REF_CLK) disable iff (SYS_RST) // R15
    (rd_load && !bus_stop && !bus_start) |=> st == ST_READ && tx == $past(rd_byte)
      && SDA_OE_N == tx[7])
    else $error("read byte not from stored register address");

endmodule // light_sensor_core

// [tb/i2c_host_model.sv]
// serial bus master model for the light sensor two-wire port
`timescale 1ns/1ps
module i2c_host_model
(
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  // ----------------------------------------
  // bit timing in clk cycles, 2.5 us a bit
  // ----------------------------------------
  localparam int Q = 130;

  initial
  begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask

  // low 260 cycles, high 240 cycles
  task automatic bit_io(input logic b, output logic s);
    pause(Q);
    sda_drv = b;
    pause(Q);
    scl = 1'b1;
    pause(120);
    s = sda_line;
    pause(120);
    scl = 1'b0;
  endtask

  task automatic start();
    sda_drv = 1'b0;
    pause(Q);
    scl = 1'b0;
  endtask

  task automatic restart();
    pause(Q);
    sda_drv = 1'b1;
    pause(Q);
    scl = 1'b1;
    pause(Q);
    start();
  endtask

  task automatic stop();
    pause(Q);
    sda_drv = 1'b0;
    pause(Q);
    scl = 1'b1;
    pause(Q);
    sda_drv = 1'b1;
    pause(2 * Q);
  endtask

  task automatic wr(input logic [7:0] d, output logic ack_n);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], ack_n);
    bit_io(1'b1, ack_n);
  endtask

  task automatic rd(input logic ack_n, output logic [7:0] d);
    logic s;
    for (int i = 0; i < 8; i++)
    begin
      bit_io(1'b1, s);
      d = {d[6:0], s};
    end
    bit_io(ack_n, s);
  endtask
endmodule // i2c_host_model

// [tb/light_sensor_core_bench.sv]
// self-checking bench for the light sensor readout
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
    end \
  end
module light_sensor_core_bench
  import light_pkg::*;
;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  localparam int          GLEN   = 4;
  localparam logic [15:0] FS     = 16'(GROUPS_SHORT * GLEN / 2 - 2);
  localparam logic [15:0] FS_MID = 16'(GROUPS_MID * GLEN / 2 - 2);
  logic        ref_clk;
  logic        osc_clk;
  logic        sys_rst;
  logic        scl;
  logic        sda_drv;
  logic        sda_out;
  logic        sda_oe_n;
  logic        sda_line;
  logic [1:0]  addr_strap;
  logic        bb_light;
  logic        ir_light;
  logic [15:0] bb_count;
  logic [15:0] ir_count;
  logic        data_update;
  logic        low_gain;
  logic [1:0]  integ_sel;
  int          n_fail;
  int          checked;
  int          cyc;

  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  light_sensor_core #(.GROUP_LEN_CYC(GLEN)) dut
  (
    .REF_CLK         (ref_clk),
    .SYS_RST         (sys_rst),
    .OSC_CLK         (osc_clk),
    .SCL_IN          (scl),
    .SDA_IN          (sda_line),
    .SDA_OUT         (sda_out),
    .SDA_OE_N        (sda_oe_n),
    .ADDR_STRAP      (addr_strap),
    .BROADBAND_LIGHT (bb_light),
    .INFRARED_LIGHT  (ir_light),
    .BROADBAND_COUNT (bb_count),
    .INFRARED_COUNT  (ir_count),
    .DATA_UPDATE     (data_update),
    .LOW_GAIN        (low_gain),
    .INTEG_SEL       (integ_sel)
  );

  i2c_host_model host
  (
    .clk      (ref_clk),
    .sda_line (sda_line),
    .scl      (scl),
    .sda_drv  (sda_drv)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial
  begin
    osc_clk = 1'b0;
    #7;
    forever #16 osc_clk = ~osc_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic test_done();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      n_fail++;
      test_done();
    end
  end

  task automatic wait_upd(output int gap);
    gap = 0;
    do
    begin
      @(negedge ref_clk);
      gap++;
    end
    while (data_update !== 1'b1 && gap < 20000);
    `CHK("update pulse", 1'b1, data_update)
  endtask

  task automatic set_timing(input logic [7:0] v);
    logic a;
    host.start();
    host.wr({ADDR_GND, 1'b0}, a);
    `CHK("addr ack", 1'b0, a)
    host.wr(8'h80 | {4'h0, REG_TIMING}, a);
    `CHK("cmd ack", 1'b0, a)
    host.wr(v, a);
    host.stop();
    `CHK("window code", v[1:0], integ_sel)
    `CHK("gain bit", v[LOW_GAIN_BIT], low_gain)
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    `CHK("reset window", INTEG_LONG, integ_sel)
    `CHK("reset gain", 1'b0, low_gain)
    `CHK("reset release", 1'b1, sda_oe_n)
    `CHK("reset count", 16'h0000, bb_count)
  endtask

  task automatic t_wrong_addr();
    logic a;
    host.start();
    host.wr({ADDR_FLOAT, 1'b0}, a);
    `CHK("foreign addr nack", 1'b1, a)
    host.stop();
  endtask

  task automatic t_low_gain();
    int g;
    logic ok;
    set_timing(8'h10);
    repeat (3) wait_upd(g);
    ok = (bb_count * 16 + 16 > FS) && (bb_count * 16 < FS + 16);
    `CHK("low gain scale", 1'b1, ok)
    `CHK("short gap ok", 1'b1, g >= 280 && g <= 283)
    `CHK("ir low gain", 16'h0000, ir_count)
  endtask

  task automatic t_high_gain();
    int g;
    set_timing(8'h01);
    repeat (3) wait_upd(g);
    `CHK("window gap ok", 1'b1, g >= 2072 && g <= 2075)
    `CHK("bb full scale", FS_MID, bb_count)
    `CHK("ir dark", 16'h0000, ir_count)
  endtask

  task automatic t_read_word();
    logic a;
    logic [7:0] d;
    logic [31:0] exp_w;
    exp_w = {16'h0000, FS_MID};
    host.start();
    host.wr({ADDR_GND, 1'b0}, a);
    host.wr(8'ha0 | {4'h0, REG_DATA0_LO}, a);
    host.restart();
    host.wr({ADDR_GND, 1'b1}, a);
    `CHK("read addr ack", 1'b0, a)
    for (int i = 0; i < 4; i++)
    begin
      host.rd(i == 3, d);
      `CHK("data byte", exp_w[8 * i +: 8], d)
    end
    host.stop();
  endtask

  task automatic t_swap_channels();
    int g;
    bb_light = 1'b0;
    ir_light = 1'b1;
    repeat (3) wait_upd(g);
    `CHK("bb dark", 16'h0000, bb_count)
    `CHK("ir full scale", FS_MID, ir_count)
    `CHK("ratio past cutoff", 1'b1, ir_count * 100 >= bb_count * 130)
  endtask

  task automatic t_strap_vdd();
    logic a;
    sys_rst    = 1'b1;
    addr_strap = STRAP_VDD;
    repeat (30) @(negedge ref_clk);
    t_reset_values();
    sys_rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    host.start();
    host.wr({ADDR_VDD, 1'b0}, a);
    `CHK("strap high ack", 1'b0, a)
    host.stop();
  endtask

  initial
  begin
    n_fail     = 0;
    checked    = 0;
    cyc        = 0;
    sys_rst    = 1'b1;
    addr_strap = STRAP_GND;
    bb_light   = 1'b1;
    ir_light   = 1'b0;
    repeat (30) @(negedge ref_clk);
    t_reset_values();
    sys_rst = 1'b0;
    repeat (8) @(negedge ref_clk);
    t_wrong_addr();
    t_low_gain();
    t_high_gain();
    t_read_word();
    t_swap_channels();
    t_strap_vdd();
    test_done();
  end
endmodule // light_sensor_core_bench
